/* File: rtl/dac_pkg.sv */
// Constants, register map and types for the DMA address, count and status block
package dac_pkg;
  localparam int NCH = 4;                       // Number of channels
  localparam int CH_W = 2;                      // Channel number width
  localparam int RAM_W = 24;                    // RAM address width
  localparam int HI_W = 8;                      // Bits held in a high address register
  localparam int LO_W = 16;                     // Bits held in a low address register
  localparam int PAD_W = 16;                    // Peripheral address width
  localparam int CNT_W = 14;                    // Transfer count width
  localparam int PADDR_W = 8;                   // APB byte address width
  localparam int DATA_W = 32;                   // APB data width
  localparam int IRQ_W = 12;                    // Interrupt status width

  typedef logic [RAM_W-1:0] dac_ram_addr_t;
  typedef logic [PAD_W-1:0] dac_pad_t;
  typedef logic [CNT_W-1:0] dac_cnt_t;
  typedef logic [PADDR_W-1:0] dac_paddr_t;
  typedef logic [DATA_W-1:0] dac_data_t;
  typedef logic [CH_W-1:0] dac_ch_t;
  typedef logic [NCH-1:0] dac_chvec_t;
  typedef logic [IRQ_W-1:0] dac_irq_t;

  // Per-channel block of registers, byte offsets within the block
  localparam dac_paddr_t CH_STRIDE = 8'h20;
  localparam dac_paddr_t OFF_CTRL = 8'h00;
  localparam dac_paddr_t OFF_PRI_HI = 8'h04;
  localparam dac_paddr_t OFF_PRI_LO = 8'h08;
  localparam dac_paddr_t OFF_SEC_HI = 8'h0c;
  localparam dac_paddr_t OFF_SEC_LO = 8'h10;
  localparam dac_paddr_t OFF_PAD = 8'h14;
  localparam dac_paddr_t OFF_CNT = 8'h18;
  // Shared registers
  localparam dac_paddr_t OFF_LAST_HI = 8'h80;
  localparam dac_paddr_t OFF_LAST_LO = 8'h84;
  localparam dac_paddr_t OFF_PWC = 8'h88;
  localparam dac_paddr_t OFF_RQC = 8'h8c;
  localparam dac_paddr_t OFF_IRQ_STAT = 8'h90;
  localparam dac_paddr_t OFF_IRQ_MASK = 8'h94;
  localparam dac_paddr_t OFF_BUF_SEL = 8'h98;

  // Channel control field positions
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_DIR_BIT = 13;
  localparam int CTRL_FORCE_BIT = 8;
  localparam int CTRL_MODE_LSB = 0;
  localparam int MODE_ONESHOT_BIT = 0;          // Mode bit 0: one-shot
  localparam int MODE_PP_BIT = 1;               // Mode bit 1: ping-pong

  // Interrupt status layout
  localparam int IRQ_DONE_LSB = 0;
  localparam int IRQ_PWC_LSB = 4;
  localparam int IRQ_RQC_LSB = 8;

  typedef enum logic [0:0] {
    DAC_IDLE = 1'b0,
    DAC_BUSY = 1'b1
  } dac_state_t;
endpackage

/* File: rtl/dac_seq_if.sv */
// Signals between the register block and one channel sequencer
`timescale 1ns/100ps
`default_nettype none
interface dac_seq_if;
  import dac_pkg::*;
  logic enable;          // Channel enabled
  dac_cnt_t count;       // Programmed count
  logic ping_pong;       // Ping-pong buffering on
  logic one_shot;        // Stop after the last block
  logic step;            // One transfer of this channel completed
  dac_cnt_t index;       // Transfers done in the current block
  logic buf_sel;         // 1: secondary buffer selected
  logic block_done;      // Pulse: last transfer of a block
  logic finished;        // Pulse: one-shot sequence over
  modport owner (output enable, count, ping_pong, one_shot, step,
                 input index, buf_sel, block_done, finished);
  modport seq (input enable, count, ping_pong, one_shot, step,
               output index, buf_sel, block_done, finished);
endinterface
`default_nettype wire

/* File: rtl/dac_irq.sv */
// Sticky interrupt status with write-one-to-clear and a mask
`timescale 1ns/100ps
`default_nettype none
module dac_irq
  import dac_pkg::*;
(
  input wire logic i_clock,            // System clock
  input wire logic i_resetn,           // Synchronous reset, active low
  input wire dac_pkg::dac_irq_t i_event, // Event pulses
  input wire logic i_clr_we,           // Write to the status register
  input wire logic i_mask_we,          // Write to the mask register
  input wire dac_pkg::dac_irq_t i_wdata, // Write data
  output dac_pkg::dac_irq_t o_status,  // Sticky status
  output dac_pkg::dac_irq_t o_mask,    // Mask, 1 passes the bit
  output logic o_irq                   // Level interrupt
);
  dac_irq_t stat_q;
  dac_irq_t mask_q;
  dac_irq_t clr;

  // A clear never swallows an event that lands in the same cycle
  always_comb begin
    clr = i_clr_we ? i_wdata : '0;
  end

  // Status: set wins over the clear
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | i_event;
    end
  end

  // Mask register
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      mask_q <= '0;
    end else if (i_mask_we) begin
      mask_q <= i_wdata;
    end
  end

  assign o_status = stat_q;
  assign o_mask = mask_q;
  assign o_irq = |(stat_q & mask_q);
endmodule
`default_nettype wire

/* File: rtl/dac_seq.sv */
// One channel's block counter and ping-pong buffer selection
`timescale 1ns/100ps
`default_nettype none
module dac_seq
  import dac_pkg::*;
(
  input wire logic i_clock,   // System clock
  input wire logic i_resetn,  // Synchronous reset, active low
  dac_seq_if.seq s            // Link to the register block
);
  dac_cnt_t idx_q;            // Position in the block
  logic buf_q;                // Current buffer
  logic last;                 // This step ends the block

  assign last = s.step && (idx_q == s.count);

  // A block is count plus one steps; index wraps after the last one
  always_ff @(posedge i_clock) begin
    if (!i_resetn || !s.enable) begin
      idx_q <= '0;
      buf_q <= 1'b0;
    end else if (s.step) begin
      if (last) begin
        idx_q <= '0; // RULE4
        if (s.ping_pong) begin
          buf_q <= ~buf_q; // RULE13
        end
      end else begin
        idx_q <= dac_cnt_t'(idx_q + 1'b1); // RULE4
      end
    end
  end

  // One-shot ping-pong ends after one block in each buffer
  assign s.block_done = last;
  assign s.finished = last && s.one_shot && (!s.ping_pong || buf_q); // RULE12
  assign s.index = idx_q;
  assign s.buf_sel = buf_q;
endmodule
`default_nettype wire

/* File: rtl/dac_top.sv */
// DMA channel address, count and shared status registers with APB access
// Functional notes
// RULE1: Each channel keeps a 24-bit primary start address.
// RULE2: Each channel keeps a 24-bit secondary start address.
// RULE3: Each channel keeps a read/write 16-bit peripheral address.
// RULE4: A block is programmed count plus one transfers.
// RULE5: Software avoids rewriting address or count while enabled.
// RULE6: Read-only last RAM address, zero after reset.
// RULE7: Per-channel peripheral write collision flags, bits 3-0.
// RULE8: Per-channel force versus request collision flags.
// RULE9: Unused register bits read as zero.
// RULE10: Force starts one transfer; only hardware clears it. Here disabling the channel also clears it.
// RULE11: Direction set: RAM to peripheral, else reverse.
// RULE12: Mode 10 continuous, 11 one-shot ping-pong.
// RULE13: Ping-pong swaps start address after each block.
`timescale 1ns/100ps
`default_nettype none
module dac_top
  import dac_pkg::*;
(
  input wire logic i_clock,                    // 200 MHz system clock
  input wire logic i_resetn,                   // Synchronous reset, active low
  input wire logic i_psel,                     // APB select
  input wire logic i_penable,                  // APB access phase
  input wire logic i_pwrite,                   // APB write
  input wire dac_pkg::dac_paddr_t i_paddr,     // APB byte address
  input wire dac_pkg::dac_data_t i_pwdata,     // APB write data
  output dac_pkg::dac_data_t o_prdata,         // APB read data
  output logic o_pready,                       // APB ready
  output logic o_pslverr,                      // APB error
  input wire dac_pkg::dac_chvec_t i_request,   // Peripheral request pulses
  input wire dac_pkg::dac_chvec_t i_periph_wcol, // Peripheral write collision pulses
  output logic o_xfer_valid,                   // Transfer requested
  input wire logic i_xfer_ready,               // Transfer taken
  output dac_pkg::dac_ch_t o_xfer_chan,        // Channel of the transfer
  output dac_pkg::dac_ram_addr_t o_ram_addr,   // RAM address
  output dac_pkg::dac_pad_t o_periph_addr,     // Peripheral address
  output logic o_xfer_dir,                     // 1: RAM to peripheral
  output logic o_irq                           // Level interrupt
);
  import dac_pkg::*;

  // Address decode used for every register of every channel
  function automatic logic reg_hit(dac_paddr_t a, int ch, dac_paddr_t off);
    reg_hit = (a == dac_paddr_t'(ch * CH_STRIDE + off));
  endfunction

  // Channel registers
  logic [HI_W-1:0] pri_hi_q [NCH];   // Primary start, upper byte
  logic [LO_W-1:0] pri_lo_q [NCH];   // Primary start, lower half
  logic [HI_W-1:0] sec_hi_q [NCH];   // Secondary start, upper byte
  logic [LO_W-1:0] sec_lo_q [NCH];   // Secondary start, lower half
  dac_pad_t pad_q [NCH];             // Peripheral address
  dac_cnt_t cnt_q [NCH];             // Transfer count
  logic [1:0] mode_q [NCH];          // Operating mode
  dac_chvec_t en_q;                  // Channel enable
  dac_chvec_t dir_q;                 // Direction
  dac_chvec_t force_q;               // Manual transfer pending
  dac_chvec_t reqp_q;                // Peripheral request pending
  dac_chvec_t pwc_q;                 // Write collision flags
  dac_chvec_t rqc_q;                 // Request collision flags
  dac_ram_addr_t last_q;             // Most recent RAM address
  // Engine state
  dac_state_t state_q;               // Idle or transfer offered
  dac_ch_t cur_q;                    // Channel being served
  logic src_force_q;                 // Current transfer came from force
  dac_ram_addr_t ram_addr_q;         // Registered RAM address
  dac_pad_t pad_out_q;               // Registered peripheral address
  logic dir_out_q;                   // Registered direction
  // APB
  dac_data_t prdata_q;               // Read data captured in setup
  logic pslverr_q;                   // Error captured in setup
  dac_data_t rd_d;                   // Read mux
  logic hit_d;                       // Address maps to a register
  wire logic wr = i_psel && i_penable && i_pwrite; // Write takes effect this edge
  wire logic setup = i_psel && !i_penable; // Setup phase
  // Arbitration and sequencers
  logic gnt_any;                     // A channel wants service
  dac_ch_t gnt_ch;                   // Lowest numbered such channel
  wire logic accept = (state_q == DAC_BUSY) && i_xfer_ready; // Transfer taken this edge
  dac_chvec_t step;                  // Per-channel completion
  dac_chvec_t blk_done;              // Per-channel block end
  dac_chvec_t fin;                   // Per-channel one-shot end
  dac_chvec_t bufsel;                // Per-channel buffer select
  dac_cnt_t index [NCH];             // Per-channel block position
  dac_chvec_t rqc_evt;               // Request collision events
  dac_chvec_t pwc_evt;               // Write collision events
  dac_irq_t irq_evt;                 // Interrupt events
  dac_irq_t irq_stat;                // Interrupt status
  dac_irq_t irq_mask;                // Interrupt mask

  // One sequencer per channel
  dac_seq_if u_if [NCH] ();
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign u_if[g].enable = en_q[g];
    assign u_if[g].count = cnt_q[g];
    assign u_if[g].ping_pong = mode_q[g][MODE_PP_BIT];
    assign u_if[g].one_shot = mode_q[g][MODE_ONESHOT_BIT];
    assign u_if[g].step = step[g];
    assign step[g] = accept && (cur_q == dac_ch_t'(g));
    assign blk_done[g] = u_if[g].block_done;
    assign fin[g] = u_if[g].finished;
    assign bufsel[g] = u_if[g].buf_sel;
    assign index[g] = u_if[g].index;
    dac_seq u_seq (
      .i_clock (i_clock),
      .i_resetn (i_resetn),
      .s (u_if[g])
    );
  end

  // Collision events only count on an enabled channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pwc_evt[c] = en_q[c] && i_periph_wcol[c]; // RULE7
      // Request meets a pending force, or force written over a pending request
      rqc_evt[c] = en_q[c] && ((i_request[c] && force_q[c]) || (reqp_q[c] && wr
                   && reg_hit(i_paddr, c, OFF_CTRL) && i_pwdata[CTRL_FORCE_BIT])); // RULE8
    end
  end

  // Address, count and control registers; written only in the access phase
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int c = 0; c < NCH; c++) begin
        pri_hi_q[c] <= '0;
        pri_lo_q[c] <= '0;
        sec_hi_q[c] <= '0;
        sec_lo_q[c] <= '0;
        pad_q[c] <= '0;
        cnt_q[c] <= '0;
        mode_q[c] <= '0;
      end
      en_q <= '0;
      dir_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        // A finished one-shot sequence drops the enable
        if (fin[c]) begin
          en_q[c] <= 1'b0; // RULE12
        end
        if (wr && reg_hit(i_paddr, c, OFF_CTRL)) begin
          en_q[c] <= i_pwdata[CTRL_EN_BIT];
          dir_q[c] <= i_pwdata[CTRL_DIR_BIT];
          mode_q[c] <= i_pwdata[CTRL_MODE_LSB +: 2];
        end
        if (wr && reg_hit(i_paddr, c, OFF_PRI_HI)) begin
          pri_hi_q[c] <= i_pwdata[HI_W-1:0]; // RULE1
        end
        if (wr && reg_hit(i_paddr, c, OFF_PRI_LO)) begin
          pri_lo_q[c] <= i_pwdata[LO_W-1:0]; // RULE1
        end
        if (wr && reg_hit(i_paddr, c, OFF_SEC_HI)) begin
          sec_hi_q[c] <= i_pwdata[HI_W-1:0]; // RULE2
        end
        if (wr && reg_hit(i_paddr, c, OFF_SEC_LO)) begin
          sec_lo_q[c] <= i_pwdata[LO_W-1:0]; // RULE2
        end
        // Rewriting these while enabled is left to software discipline
        if (wr && reg_hit(i_paddr, c, OFF_PAD)) begin
          pad_q[c] <= i_pwdata[PAD_W-1:0]; // RULE3 RULE5
        end
        if (wr && reg_hit(i_paddr, c, OFF_CNT)) begin
          cnt_q[c] <= i_pwdata[CNT_W-1:0]; // RULE4 RULE5
        end
      end
    end
  end
  // Force and request pending bits; a new set beats a same-cycle clear
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      force_q <= '0;
      reqp_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!en_q[c]) begin
          force_q[c] <= 1'b0; // RULE10
          reqp_q[c] <= 1'b0;
        end else begin
          // Software writes of zero have no effect on the force bit
          force_q[c] <= (force_q[c] && !(step[c] && src_force_q))
                        || (wr && reg_hit(i_paddr, c, OFF_CTRL)
                        && i_pwdata[CTRL_FORCE_BIT]); // RULE10
          reqp_q[c] <= (reqp_q[c] && !(step[c] && !src_force_q)) || i_request[c];
        end
      end
    end
  end
  // Collision flags: sticky, cleared only by disabling the channel
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pwc_q <= '0;
      rqc_q <= '0;
    end else begin
      pwc_q <= (pwc_q & en_q) | pwc_evt; // RULE7
      rqc_q <= (rqc_q & en_q) | rqc_evt; // RULE8
    end
  end
  // Fixed priority: lowest channel number first; force served before request
  always_comb begin
    gnt_any = 1'b0;
    gnt_ch = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (en_q[c] && (force_q[c] || reqp_q[c])) begin
        gnt_any = 1'b1;
        gnt_ch = dac_ch_t'(c);
      end
    end
  end

  // Transfer engine: latch the addresses at grant, hold until taken
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_q <= DAC_IDLE;
      cur_q <= '0;
      src_force_q <= 1'b0;
      ram_addr_q <= '0;
      pad_out_q <= '0;
      dir_out_q <= 1'b0;
    end else begin
      unique case (state_q)
        DAC_IDLE: begin
          if (gnt_any) begin
            state_q <= DAC_BUSY;
            cur_q <= gnt_ch;
            src_force_q <= force_q[gnt_ch];
            // Ping-pong picks the buffer the sequencer points at
            ram_addr_q <= dac_ram_addr_t'((bufsel[gnt_ch]
                          ? {sec_hi_q[gnt_ch], sec_lo_q[gnt_ch]}
                          : {pri_hi_q[gnt_ch], pri_lo_q[gnt_ch]})
                          + dac_ram_addr_t'(index[gnt_ch])); // RULE1 RULE2 RULE13
            pad_out_q <= pad_q[gnt_ch]; // RULE3
            dir_out_q <= dir_q[gnt_ch]; // RULE11
          end
        end
        DAC_BUSY: begin
          // A channel disabled mid-offer still completes this transfer
          if (i_xfer_ready) begin
            state_q <= DAC_IDLE;
          end
        end
      endcase
    end
  end
  // Most recent RAM address touched
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      last_q <= '0; // RULE6
    end else if (accept) begin
      last_q <= ram_addr_q; // RULE6
    end
  end
  // Interrupt events
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_DONE_LSB +: NCH] = blk_done;
    irq_evt[IRQ_PWC_LSB +: NCH] = pwc_evt;
    irq_evt[IRQ_RQC_LSB +: NCH] = rqc_evt;
  end

  dac_irq u_irq (
    .i_clock (i_clock),
    .i_resetn (i_resetn),
    .i_event (irq_evt),
    .i_clr_we (wr && reg_hit(i_paddr, 0, OFF_IRQ_STAT)),
    .i_mask_we (wr && reg_hit(i_paddr, 0, OFF_IRQ_MASK)),
    .i_wdata (i_pwdata[IRQ_W-1:0]),
    .o_status (irq_stat),
    .o_mask (irq_mask),
    .o_irq (o_irq)
  );

  // Read mux; every unused bit is zero by construction
  always_comb begin
    rd_d = '0;
    hit_d = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (reg_hit(i_paddr, c, OFF_CTRL)) begin
        hit_d = 1'b1;
        rd_d[CTRL_EN_BIT] = en_q[c];
        rd_d[CTRL_DIR_BIT] = dir_q[c];
        rd_d[CTRL_FORCE_BIT] = force_q[c];
        rd_d[CTRL_MODE_LSB +: 2] = mode_q[c];
      end
      if (reg_hit(i_paddr, c, OFF_PRI_HI)) begin
        hit_d = 1'b1;
        rd_d[HI_W-1:0] = pri_hi_q[c]; // RULE9
      end
      if (reg_hit(i_paddr, c, OFF_PRI_LO)) begin
        hit_d = 1'b1;
        rd_d[LO_W-1:0] = pri_lo_q[c];
      end
      if (reg_hit(i_paddr, c, OFF_SEC_HI)) begin
        hit_d = 1'b1;
        rd_d[HI_W-1:0] = sec_hi_q[c]; // RULE9
      end
      if (reg_hit(i_paddr, c, OFF_SEC_LO)) begin
        hit_d = 1'b1;
        rd_d[LO_W-1:0] = sec_lo_q[c];
      end
      if (reg_hit(i_paddr, c, OFF_PAD)) begin
        hit_d = 1'b1;
        rd_d[PAD_W-1:0] = pad_q[c];
      end
      if (reg_hit(i_paddr, c, OFF_CNT)) begin
        hit_d = 1'b1;
        rd_d[CNT_W-1:0] = cnt_q[c]; // RULE9
      end
    end
    unique case (i_paddr)
      OFF_LAST_HI: begin
        hit_d = 1'b1;
        rd_d[HI_W-1:0] = last_q[RAM_W-1:LO_W]; // RULE6 RULE9
      end
      OFF_LAST_LO: begin
        hit_d = 1'b1;
        rd_d[LO_W-1:0] = last_q[LO_W-1:0]; // RULE6
      end
      OFF_PWC: begin
        hit_d = 1'b1;
        rd_d[NCH-1:0] = pwc_q; // RULE7 RULE9
      end
      OFF_RQC: begin
        hit_d = 1'b1;
        rd_d[NCH-1:0] = rqc_q; // RULE8 RULE9
      end
      OFF_IRQ_STAT: begin
        hit_d = 1'b1;
        rd_d[IRQ_W-1:0] = irq_stat;
      end
      OFF_IRQ_MASK: begin
        hit_d = 1'b1;
        rd_d[IRQ_W-1:0] = irq_mask;
      end
      OFF_BUF_SEL: begin
        hit_d = 1'b1;
        rd_d[NCH-1:0] = bufsel;
      end
      default: begin
        // Channel registers decoded above, or unmapped
      end
    endcase
  end
  // Read data and error are captured in setup so the access phase has no wait
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= i_pwrite ? '0 : rd_d;
      pslverr_q <= !hit_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_q && i_psel && i_penable;
  assign o_xfer_valid = (state_q == DAC_BUSY);
  assign o_xfer_chan = cur_q;
  assign o_ram_addr = ram_addr_q;
  assign o_periph_addr = pad_out_q;
  assign o_xfer_dir = dir_out_q;
endmodule
`default_nettype wire

/* File: bench/dac_checker.sv */
// Port-level assertions for the DMA register block
`timescale 1ns/100ps
`default_nettype none
module dac_checker
  import dac_pkg::*;
(
  input wire logic i_clock, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB access
  input wire logic i_pwrite, // APB write
  input wire dac_pkg::dac_paddr_t i_paddr, // APB address
  input wire dac_pkg::dac_data_t o_prdata, // Read data
  input wire logic o_pready, // Ready
  input wire logic o_pslverr, // Error
  input wire logic o_xfer_valid, // Offer
  input wire logic i_xfer_ready, // Taken
  input wire dac_pkg::dac_ch_t o_xfer_chan, // Channel
  input wire dac_pkg::dac_ram_addr_t o_ram_addr, // RAM address
  input wire dac_pkg::dac_pad_t o_periph_addr, // Peripheral address
  input wire logic o_xfer_dir // Direction
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic mapped; // Aligned and inside a channel block or the shared area
  assign mapped = i_paddr[1:0] == 2'h0 &&
    (i_paddr[7] ? i_paddr <= 8'h98 : i_paddr[4:0] <= 5'h18);
  sequence s_access;
    i_psel && i_penable;
  endsequence
  sequence s_offer;
    o_xfer_valid && !i_xfer_ready;
  endsequence
  sequence s_take;
    o_xfer_valid && i_xfer_ready;
  endsequence
  a_ready_high: assert property (o_pready) else $error("pready low");
  a_err_phase: assert property (o_pslverr |-> i_psel && i_penable) else $error("stray error");
  a_err_unmapped: assert property (s_access ##0 !mapped |-> o_pslverr)
    else $error("unmapped without error");
  a_ok_mapped: assert property (s_access ##0 mapped |-> !o_pslverr)
    else $error("mapped with error");
  a_wr_zero: assert property (s_access ##0 i_pwrite |-> o_prdata == '0)
    else $error("read data on write");
  a_rd_stand: assert property (s_access ##0 !i_pwrite |=> $stable(o_prdata))
    else $error("read data moved");
  // Offer must not move while the far side stalls
  a_offer_hold: assert property (s_offer |=> o_xfer_valid &&
    $stable({o_xfer_chan, o_ram_addr, o_periph_addr, o_xfer_dir})) else $error("offer moved");
  a_take_gap: assert property (s_take |=> !o_xfer_valid)
    else $error("no idle after accept");
endmodule
`default_nettype wire

/* File: bench/dac_xfer_model.sv */
// Far-side model of RAM and peripherals taking transfers
`timescale 1ns/100ps
`default_nettype none
module dac_xfer_model #(
  parameter int DLY = 1 // Offered cycles before taking
) (
  input wire logic i_clock, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_valid, // Transfer offered
  input wire logic i_hold, // Bench stall
  output logic o_ready // Transfer taken
);
  logic [3:0] wait_q; // Offered cycles so far
  // Ready lasts one cycle, so one offer is never taken twice
  always_ff @(posedge i_clock) begin
    if (!i_resetn || !i_valid || o_ready) begin
      wait_q <= 4'h0;
      o_ready <= 1'b0;
    end else begin
      o_ready <= !i_hold && wait_q >= 4'(DLY);
      wait_q <= wait_q + {3'h0, wait_q != 4'hf};
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the DMA register block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dac_pkg::*;
  logic i_clock = 1'b0; // Clock
  logic i_resetn = 1'b0; // Reset, active low
  logic ps = 1'b0, pe = 1'b0, pw = 1'b0, hold = 1'b0; // Bus controls, stall
  dac_paddr_t pa = '0; // Bus address
  dac_data_t pd = '0, prd, rv; // Bus data, captured read
  logic prdy, perr, ev, xv, xr, xdir, irq, ld; // Status
  dac_chvec_t req = '0, wcol = '0; // Event pulses
  dac_ch_t xch, lc; // Channel offered, last taken
  dac_ram_addr_t xa; // RAM address offered
  dac_pad_t xp, lp; // Peripheral address offered, last taken
  dac_ram_addr_t got[$]; // Accepted RAM addresses
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  localparam dac_data_t EN = 32'h1 << CTRL_EN_BIT;
  localparam dac_data_t DIR = 32'h1 << CTRL_DIR_BIT;
  localparam dac_data_t FRC = 32'h1 << CTRL_FORCE_BIT;
  localparam dac_paddr_t OFS[6] = '{OFF_PRI_HI, OFF_PRI_LO, OFF_SEC_HI, OFF_SEC_LO, OFF_PAD, OFF_CNT};
  localparam dac_data_t MSK[6] = '{32'hff, 32'hffff, 32'hff, 32'hffff, 32'hffff, 32'h3fff};
  always #2.5 i_clock = ~i_clock;
  dac_top uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(ps), .i_penable(pe),
    .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .i_request(req), .i_periph_wcol(wcol), .o_xfer_valid(xv),
    .i_xfer_ready(xr), .o_xfer_chan(xch), .o_ram_addr(xa), .o_periph_addr(xp),
    .o_xfer_dir(xdir), .o_irq(irq));
  dac_xfer_model model (.i_clock(i_clock), .i_resetn(i_resetn), .i_valid(xv),
    .i_hold(hold), .o_ready(xr));
  // Log each accepted transfer
  always @(posedge i_clock) begin
    cyc++;
    if (xv === 1'b1 && xr === 1'b1) begin
      got.push_back(xa);
      lc = xch;
      ld = xdir;
      lp = xp;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input dac_data_t g, input dac_data_t e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input dac_paddr_t a, input dac_data_t d);
    @(posedge i_clock);
    ps <= 1'b1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge i_clock);
    pe <= 1'b1;
    do @(posedge i_clock); while (prdy !== 1'b1);
    rv = prd;
    ev = perr;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask
  task automatic wr(input dac_paddr_t a, input dac_data_t d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input dac_paddr_t a, input dac_data_t e);
    apb(1'b0, a, '0);
    chk(rv, e);
  endtask
  task automatic rde(input dac_paddr_t a);
    rd(a, '0);
    chk(32'(ev), 32'h1);
  endtask
  task automatic pulse(input dac_chvec_t r, input dac_chvec_t w);
    @(posedge i_clock);
    req <= r;
    wcol <= w;
    @(posedge i_clock);
    req <= '0;
    wcol <= '0;
  endtask
  // Bounded wait for k accepted transfers
  task automatic wait_x(input int k);
    for (int i = 0; i < 200 && got.size() < k; i++) @(posedge i_clock);
    chk(32'(got.size()), 32'(k));
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd(OFF_LAST_HI, '0);
    wr(OFF_LAST_LO, '1);
    rd(OFF_LAST_LO, '0);
    rde(8'h1c);
    rde(8'h9c);
    rde(8'h02);
    done("reset");
    for (int c = 0; c < NCH; c++) begin
      for (int i = 0; i < 6; i++) begin
        wr(dac_paddr_t'(c * 32) + OFS[i], '1);
        rd(dac_paddr_t'(c * 32) + OFS[i], MSK[i]);
        wr(dac_paddr_t'(c * 32) + OFS[i], '0);
        rd(dac_paddr_t'(c * 32) + OFS[i], '0);
      end
    end
    done("fields");
    // Channel 1: one-shot ping-pong, three transfers a block
    wr(8'h24, 32'h12);
    wr(8'h28, 32'h3450);
    wr(8'h2c, 32'h0a);
    wr(8'h34, 32'h42);
    wr(8'h38, 32'h2);
    wr(8'h20, EN | DIR | 32'h3);
    for (int i = 0; i < 6; i++) begin
      pulse(4'h2, 4'h0);
      wait_x(i + 1);
      chk(32'(got[i]), i < 3 ? 32'h123450 + i : 32'h0a0000 + i - 3);
      if (i == 2) begin
        rd(OFF_BUF_SEL, 32'h2);
      end
    end
    chk(32'({lc, ld, lp}), 32'h30042);
    pulse(4'h2, 4'h0);
    repeat (10) @(posedge i_clock);
    chk(32'(got.size()), 32'h6);
    rd(8'h20, DIR | 32'h3);
    rd(OFF_LAST_HI, 32'h0a);
    rd(OFF_LAST_LO, 32'h2);
    done("ping_pong");
    // Channel 0 forced, peripheral to RAM
    wr(8'h08, 32'h100);
    wr(8'h00, EN);
    wr(8'h00, EN | FRC);
    wait_x(7);
    chk(32'({lc, ld, got[6]}), 32'h100);
    rd(8'h00, EN);
    // Channel 2 force stalled; a zero write leaves it set, then both collisions
    hold <= 1'b1;
    wr(8'h40, EN);
    wr(8'h40, EN | FRC);
    wr(8'h40, EN);
    rd(8'h40, EN | FRC);
    pulse(4'h4, 4'h4);
    rd(OFF_RQC, 32'h4);
    rd(OFF_PWC, 32'h4);
    hold <= 1'b0;
    wait_x(9);
    wr(8'h40, '0);
    rd(OFF_RQC, '0);
    rd(OFF_PWC, '0);
    done("force");
    rd(OFF_IRQ_STAT, 32'h447);
    chk(32'(irq), '0);
    wr(OFF_IRQ_MASK, 32'h2);
    #1 chk(32'(irq), 32'h1);
    wr(OFF_IRQ_STAT, 32'h2);
    #1 chk(32'(irq), '0);
    rd(OFF_IRQ_STAT, 32'h445);
    done("irq");
    final_report();
  end
endmodule
bind dac_top dac_checker chk_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_xfer_valid(o_xfer_valid),
  .i_xfer_ready(i_xfer_ready), .o_xfer_chan(o_xfer_chan), .o_ram_addr(o_ram_addr),
  .o_periph_addr(o_periph_addr), .o_xfer_dir(o_xfer_dir));
`default_nettype wire
